// File: shared/gain_fmt_pkg.sv
// Purpose: Constants for the sample word gain formatter.
// Assumes: 12-bit converter codes, 16-bit internal words.
// Notes: Gains are fixed point with 1024 meaning unity.
package gain_fmt_pkg;
  localparam int RAW_W = 12;
  localparam int WORD_W = 16;
  localparam int FRAC_W = 4;
  localparam int GAIN_W = 16;
  localparam int GAIN_SHIFT = 10;
  localparam logic [GAIN_W-1:0] UNITY_GAIN = 16'h0400;
  localparam logic signed [WORD_W-1:0] WORD_MAX = 16'sh7fff;
  localparam logic signed [WORD_W-1:0] WORD_MIN = 16'sh8000;
  localparam int OVERRIDE_BIT = 7;
  localparam int SEL_W = 8;
  localparam real DATA_CLK_MHZ = 312.5;
endpackage : gain_fmt_pkg

// File: shared/gain_stage_if.sv
// Purpose: Carries one gain and offset stage between formatter modules.
// Assumes: Single data clock.
// Notes: Stage input is a signed word, output is saturated word.
`timescale 1ns/1ps
interface gain_stage_if;
  import gain_fmt_pkg::*;
  logic valid_in;
  logic signed [WORD_W-1:0] word_in;
  logic ovf_in;
  logic [GAIN_W-1:0] gain;
  logic signed [WORD_W-1:0] offset;
  logic valid_out;
  logic signed [WORD_W-1:0] word_out;
  logic ovf_out;
  modport stage (input valid_in, word_in, ovf_in, gain, offset,
                 output valid_out, word_out, ovf_out);
  modport feed (output valid_in, word_in, ovf_in, gain, offset,
                input valid_out, word_out, ovf_out);
endinterface : gain_stage_if

// File: src/gain_stage.sv
// Purpose: One multiply by gain/1024, subtract offset, saturate.
// Assumes: Gain is unsigned fixed point, 1024 is unity.
// Notes: One register of latency; overflow flag rides with the word.
`timescale 1ns/1ps
module gain_stage (
  input wire logic i_clk,
  input wire logic i_rst,
  gain_stage_if.stage port
);
  import gain_fmt_pkg::*;
  localparam int PROD_W = WORD_W + GAIN_W + 2;
  localparam logic signed [PROD_W-1:0] LIM_HI = PROD_W'(WORD_MAX);
  localparam logic signed [PROD_W-1:0] LIM_LO = PROD_W'(WORD_MIN);

  logic signed [PROD_W-1:0] prod;
  logic signed [PROD_W-1:0] diff;
  logic valid;
  logic signed [WORD_W-1:0] word;
  logic ovf;
  logic next_valid;
  logic signed [WORD_W-1:0] next_word;
  logic next_ovf;

  // Scale, drop ten fraction bits, subtract offset, clamp
  always_comb begin
    prod = (PROD_W'(port.word_in) *
            $signed({2'b00, port.gain})) >>> GAIN_SHIFT;
    diff = prod - PROD_W'(port.offset);
    next_valid = port.valid_in;
    // Flag rides only with a real word, never with idle bus junk
    next_ovf = port.valid_in & port.ovf_in;
    if (diff > LIM_HI) begin
      next_word = WORD_MAX;
      next_ovf = port.valid_in;
    end else if (diff < LIM_LO) begin
      next_word = WORD_MIN;
      next_ovf = port.valid_in;
    end else begin
      next_word = diff[WORD_W-1:0];
    end
  end

  // Pipeline register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      valid <= 1'b0;
      word <= '0;
      ovf <= 1'b0;
    end else begin
      valid <= next_valid;
      word <= next_word;
      ovf <= next_ovf;
    end
  end

  assign port.valid_out = valid;
  assign port.word_out = word;
  assign port.ovf_out = ovf;
endmodule : gain_stage

// File: src/sample_word_gain_formatter.sv
// Purpose: Turn 12-bit converter codes into corrected 16-bit words.
// Assumes: One data clock at 312.5 MHz; gains and offsets held steady.
// Notes: Three cycles from raw sample to corrected word.
// Overview of operation
// - Raw code sits in top twelve bits
// - Words are signed two's complement sixteen bit
// - Any stage overflow clamps and flags
// - Fraction bits kept in four low bits
// - Gain factor is input port value over 1024
// - Everything runs on the single data clock
// - Default: raw times cal gain minus cal offset, then user gain and offset
// - Override bit uses user values only
`timescale 1ns/1ps
module sample_word_gain_formatter (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_raw_valid,
  input wire logic [gain_fmt_pkg::RAW_W-1:0] i_raw_code,
  input wire logic [gain_fmt_pkg::SEL_W-1:0] i_channel_sel,
  input wire logic [gain_fmt_pkg::GAIN_W-1:0] i_cal_gain,
  input wire logic signed [gain_fmt_pkg::WORD_W-1:0] i_cal_offset,
  input wire logic [gain_fmt_pkg::GAIN_W-1:0] i_user_gain,
  input wire logic signed [gain_fmt_pkg::WORD_W-1:0] i_user_offset,
  output logic o_word_valid,
  output logic [gain_fmt_pkg::WORD_W-1:0] o_word,
  output logic o_overflow
);
  import gain_fmt_pkg::*;

  logic in_valid;
  logic signed [WORD_W-1:0] in_word;
  logic next_in_valid;
  logic signed [WORD_W-1:0] next_in_word;
  logic override;

  // Calibration pair taken on the same edge as its sample
  logic [GAIN_W-1:0] cal_gain;
  logic signed [WORD_W-1:0] cal_offset;
  logic [GAIN_W-1:0] next_cal_gain;
  logic signed [WORD_W-1:0] next_cal_offset;

  // User pair, held one more edge to meet the second stage
  logic [GAIN_W-1:0] user_gain_wait;
  logic signed [WORD_W-1:0] user_offset_wait;
  logic [GAIN_W-1:0] next_user_gain_wait;
  logic signed [WORD_W-1:0] next_user_offset_wait;
  logic [GAIN_W-1:0] user_gain;
  logic signed [WORD_W-1:0] user_offset;
  logic [GAIN_W-1:0] next_user_gain;
  logic signed [WORD_W-1:0] next_user_offset;

  gain_stage_if cal_if ();
  gain_stage_if user_if ();

  // Align raw code to word top, low bits zero
  always_comb begin
    next_in_valid = i_raw_valid;
    next_in_word = {i_raw_code, {FRAC_W{1'b0}}};
  end

  // Input register on the data clock
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      in_valid <= 1'b0;
      in_word <= '0;
    end else begin
      in_valid <= next_in_valid;
      in_word <= next_in_word;
    end
  end

  // Override turns the calibration stage into a unity pass
  assign override = i_channel_sel[OVERRIDE_BIT];

  // Next coefficients; each pair moves beside its sample, so a
  // setting changed mid-stream never splits one word
  always_comb begin
    if (override) begin
      next_cal_gain = UNITY_GAIN;
      next_cal_offset = '0;
    end else begin
      next_cal_gain = i_cal_gain;
      next_cal_offset = i_cal_offset;
    end
    next_user_gain_wait = i_user_gain;
    next_user_offset_wait = i_user_offset;
    next_user_gain = user_gain_wait;
    next_user_offset = user_offset_wait;
  end

  // Coefficient registers; reset leaves both stages transparent
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cal_gain <= UNITY_GAIN;
      cal_offset <= '0;
      user_gain_wait <= UNITY_GAIN;
      user_offset_wait <= '0;
      user_gain <= UNITY_GAIN;
      user_offset <= '0;
    end else begin
      cal_gain <= next_cal_gain;
      cal_offset <= next_cal_offset;
      user_gain_wait <= next_user_gain_wait;
      user_offset_wait <= next_user_offset_wait;
      user_gain <= next_user_gain;
      user_offset <= next_user_offset;
    end
  end

  // Calibration stage
  assign cal_if.valid_in = in_valid;
  assign cal_if.word_in = in_word;
  assign cal_if.ovf_in = 1'b0; // Alignment alone never overflows
  assign cal_if.gain = cal_gain;
  assign cal_if.offset = cal_offset;

  gain_stage u_cal (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .port(cal_if.stage)
  );

  // User stage on top; unity gain and zero offset make it transparent
  assign user_if.valid_in = cal_if.valid_out;
  assign user_if.word_in = cal_if.word_out;
  assign user_if.ovf_in = cal_if.ovf_out;
  assign user_if.gain = user_gain;
  assign user_if.offset = user_offset;

  gain_stage u_user (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .port(user_if.stage)
  );

  // Outputs come straight from stage registers
  assign o_word_valid = user_if.valid_out;
  assign o_word = user_if.word_out;
  assign o_overflow = user_if.ovf_out;
endmodule : sample_word_gain_formatter

// File: dv/adc_feed.sv
// Purpose: Converter model feeding raw codes
// Assumes: Called at a falling edge
// Notes: Released bus shows inverted code
`timescale 1ns/1ps
module adc_feed (
  input wire logic i_clk,
  output logic o_valid,
  output logic [11:0] o_code
);
  initial o_valid = 1'b0;
  initial o_code = '0;
  // One sample, then invert so stale data never matches
  task automatic send(input logic [11:0] c);
    o_valid = 1'b1;
    o_code = c;
    @(negedge i_clk);
    o_valid = 1'b0;
    o_code = ~c;
  endtask : send
endmodule : adc_feed

// File: dv/sample_word_gain_formatter_properties.sv
// Purpose: Port checks for the formatter
// Assumes: Gains steady while samples flow
// Notes: Bound to every formatter
`timescale 1ns/1ps
module sample_word_gain_formatter_properties
  import gain_fmt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_raw_valid,
  input wire logic [11:0] i_raw_code,
  input wire logic [7:0] i_channel_sel,
  input wire logic [15:0] i_cal_gain,
  input wire logic signed [15:0] i_cal_offset,
  input wire logic [15:0] i_user_gain,
  input wire logic signed [15:0] i_user_offset,
  input wire logic o_word_valid,
  input wire logic [15:0] o_word,
  input wire logic o_overflow
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Unity stages make the word a plain shift
  wire uu = i_user_gain == UNITY_GAIN && i_user_offset == 0;
  wire cu = i_cal_gain == UNITY_GAIN && i_cal_offset == 0;
  wire go = i_raw_valid && uu;
  AST_LAT: assert property (i_raw_valid |-> ##3 o_word_valid)
    else $error("word late");
  AST_SRC: assert property (o_word_valid |-> $past(i_raw_valid, 3))
    else $error("spurious word");
  AST_ALIGN: assert property (go && cu |-> ##3
    o_word == {$past(i_raw_code, 3), 4'h0}) else $error("misaligned");
  AST_SIGN: assert property (go && cu |-> ##3
    o_word[15] == $past(i_raw_code[11], 3)) else $error("sign lost");
  AST_CLAMP: assert property (o_overflow |->
    o_word == 16'h7fff || o_word == 16'h8000) else $error("no clamp");
  AST_FLAG: assert property (o_overflow |-> o_word_valid)
    else $error("stray flag");
  AST_DBL: assert property (go && i_cal_gain == 16'h0800 &&
    i_cal_offset == 0 && !i_channel_sel[7] && i_raw_code < 12'h400
    |-> ##3 o_word == {$past(i_raw_code[10:0], 3), 5'h0})
    else $error("bad gain");
  AST_OVR: assert property (go && i_channel_sel[7] |-> ##3
    o_word == {$past(i_raw_code, 3), 4'h0}) else $error("cal used");
  AST_RST: assert property ($fell(i_rst) |-> !o_word_valid && o_word == 0)
    else $error("reset value");
  cover property (o_overflow);
  cover property (o_word_valid && i_channel_sel[7]);
  cover property (o_word_valid && o_word[15]);
endmodule : sample_word_gain_formatter_properties
bind sample_word_gain_formatter sample_word_gain_formatter_properties chk (.*);

// File: dv/sample_word_gain_formatter_tb.sv
// Purpose: Self-checking bench for the formatter
// Assumes: Gains set before each sample
// Notes: Model floors like an arithmetic shift
`timescale 1ns/1ps
module sample_word_gain_formatter_tb;
  import gain_fmt_pkg::*;
  logic i_clk = 0, i_rst = 1, vld, ov, wv;
  logic [11:0] code;
  logic [7:0] sel = 0;
  logic [15:0] cg = UNITY_GAIN, ug = UNITY_GAIN, w;
  logic signed [15:0] co = 0, uo = 0;
  int miscompares = 0, num_checks = 0, cyc = 0;
  always #2.5 i_clk = ~i_clk;
  adc_feed feed (.i_clk(i_clk), .o_valid(vld), .o_code(code));
  sample_word_gain_formatter uut (.i_clk(i_clk), .i_rst(i_rst),
    .i_raw_valid(vld), .i_raw_code(code), .i_channel_sel(sel),
    .i_cal_gain(cg), .i_cal_offset(co), .i_user_gain(ug),
    .i_user_offset(uo), .o_word_valid(wv), .o_word(w), .o_overflow(ov));
  task automatic chk(input string n, input logic [16:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  // Two clamped stages; override swaps in unity calibration
  function automatic logic [16:0] model(input logic [11:0] r);
    longint s, g[2], o[2];
    logic f;
    g[0] = sel[7] ? 1024 : cg;
    g[1] = ug;
    o[0] = sel[7] ? 0 : co;
    o[1] = uo;
    s = 16 * signed'(r);
    f = 0;
    for (int i = 0; i < 2; i++) begin
      s = ((s * g[i]) >>> 10) - o[i];
      f |= s > 32767 || s < -32768;
      s = s > 32767 ? 32767 : (s < -32768 ? -32768 : s);
    end
    return {f, s[15:0]};
  endfunction : model
  task automatic one(input logic [11:0] r);
    logic [16:0] e;
    @(negedge i_clk);
    e = model(r);
    feed.send(r);
    // Word stands between the second and third edges after send
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk("valid", {16'h0, wv}, 17'h1);
    chk("word", {ov, w}, e);
    @(negedge i_clk);
    chk("valid drop", {16'h0, wv}, 17'h0);
  endtask : one
  // Reset mid-stream drops the word in flight
  task automatic t_rst;
    @(negedge i_clk);
    feed.send(12'h123);
    i_rst = 1;
    repeat (2) @(negedge i_clk);
    chk("rst valid", {16'h0, wv}, 17'h0);
    chk("rst word", {ov, w}, 17'h0);
    i_rst = 0;
    one(12'h321);
  endtask : t_rst
  task automatic t_pass;
    one(12'h7ff);
    one(12'h800);
  endtask : t_pass
  task automatic t_gain;
    @(negedge i_clk);
    cg = 16'h0427;
    co = 16'sh0005;
    for (int k = 0; k < 6; k++) one(12'(k));
  endtask : t_gain
  task automatic t_sat;
    @(negedge i_clk);
    cg = 16'h0800;
    co = 0;
    one(12'h100);
    one(12'h7ff);
    one(12'h800);
    @(negedge i_clk);
    uo = -16'sh7000;
    one(12'h100);
  endtask : t_sat
  task automatic t_ovr;
    @(negedge i_clk);
    sel = 8'h80;
    uo = 0;
    one(12'h9ab);
    @(negedge i_clk);
    ug = 16'h0200;
    uo = 16'sh0010;
    one(12'h7ff);
  endtask : t_ovr
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Hang guard, far beyond the roughly hundred cycles needed
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 2000) begin
      miscompares++;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 0;
    t_pass;
    t_gain;
    t_sat;
    t_ovr;
    t_rst;
    end_of_test;
  end
endmodule : sample_word_gain_formatter_tb
